// ---- pac_consts.svh ----
// register offsets, field positions, reset values and seeds of the packet engine
`ifndef PAC_CONSTS_SVH
`define PAC_CONSTS_SVH
`define PAC_OFS_PLEN 6'h06
`define PAC_OFS_CTL1 6'h07
`define PAC_OFS_CTL0 6'h08
`define PAC_OFS_ADDR 6'h09
`define PAC_OFS_STAT 6'h38
`define PAC_RST_PLEN 8'hFF
`define PAC_RST_CTL1 8'h04
`define PAC_RST_CTL0 8'h45
`define PAC_RST_ADDR 8'h00
`define PAC_CTL1_RSV_BIT 4
`define PAC_CTL0_RSV_BIT 7
`define PAC_CTL1_WMASK 8'hEF
`define PAC_CTL0_WMASK 8'h7F
`define PAC_BCAST_LO 8'h00
`define PAC_BCAST_HI 8'hFF
`define PAC_CRC_SEED 16'hFFFF
`define PAC_CRC_POLY 16'h8005
`define PAC_LEGACY_POLY 16'h1021
`define PAC_PN9_SEED 9'h1FF
`define PAC_PQ_MAX 5'h1F
`endif

// ---- pac_engine.sv ----
// packet engine: tx byte fifo, register file, receive and transmit packet handling
`timescale 1ns/1ps
`include "pac_consts.svh"

// ***************************************
// tx byte buffer
// ***************************************
module pac_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   // depth must be a power of two: the wrap bit tells full from empty
   assign in_ready = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
   assign out_valid = (wr_r != rd_r);
   assign out_data = mem[rd_r[AW-1:0]];
   // pointer advance
   always_comb
   begin
      wr_nxt = wr_r + (AW+1)'(in_valid && in_ready);
      rd_nxt = rd_r + (AW+1)'(out_valid && out_ready);
   end
   // pointers and storage
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end
   always_ff @(posedge clk)
   begin
      if (in_valid && in_ready)
         mem[wr_r[AW-1:0]] <= in_data;
   end
endmodule

// ***************************************
// packet engine top
// ***************************************
module pac_engine #(
   parameter int TXQ_DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic reg_we,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // receive bitstream from demodulator
   input wire logic rx_enable,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_sync_found,
   input wire logic [7:0] rx_rssi,
   input wire logic [6:0] rx_lqi,
   // receive bytes toward rx fifo, serial output pin
   output logic rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic rx_flush,
   output logic rx_crc_ok,
   output logic rx_serial_data,
   // transmit bytes from host
   input wire logic tx_byte_valid,
   output logic tx_byte_ready,
   input wire logic [7:0] tx_byte,
   // transmit bitstream to modulator, serial input pin
   input wire logic tx_start,
   input wire logic tx_bit_req,
   output logic tx_bit_avail,
   output logic tx_bit,
   output logic tx_busy,
   output logic tx_underflow,
   input wire logic gp_output_0_in
);
   // crc over one byte, msb first; legacy mode swaps the polynomial
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d, input logic legacy);
      logic [15:0] x;
      logic fb;
      x = c;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         fb = x[15] ^ d[i];
         x = {x[14:0], 1'b0} ^ (fb ? (legacy ? `PAC_LEGACY_POLY : `PAC_CRC_POLY) : 16'h0000);
      end
      return x;
   endfunction
   function automatic logic [8:0] pn9_step(input logic [8:0] p);
      return {p[0] ^ p[5], p[8:1]};
   endfunction
   function automatic logic [8:0] pn9_adv8(input logic [8:0] p);
      logic [8:0] x;
      x = p;
      for (int i = 0; i < 8; i++)
         x = pn9_step(x);
      return x;
   endfunction

   // ***************************************
   // registers
   // ***************************************
   pac_pkg::pac_ctl1_t c1;
   pac_pkg::pac_ctl0_t c0;
   logic [7:0] ctl1_r, ctl1_nxt, ctl0_r, ctl0_nxt, plen_r, plen_nxt, addr_r, addr_nxt;
   logic rx_busy;
   assign c1 = pac_pkg::pac_ctl1_t'(ctl1_r);
   assign c0 = pac_pkg::pac_ctl0_t'(ctl0_r);
   // reserved bits are masked off on write so they always read zero
   always_comb
   begin
      ctl1_nxt = ctl1_r;
      ctl0_nxt = ctl0_r;
      plen_nxt = plen_r;
      addr_nxt = addr_r;
      if (reg_we)
      begin
         unique case (reg_addr)
            `PAC_OFS_CTL1: ctl1_nxt = reg_wdata & `PAC_CTL1_WMASK;
            `PAC_OFS_CTL0: ctl0_nxt = reg_wdata & `PAC_CTL0_WMASK;
            `PAC_OFS_PLEN: plen_nxt = reg_wdata;
            `PAC_OFS_ADDR: addr_nxt = reg_wdata;
            default: ;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl1_r <= `PAC_RST_CTL1;
         ctl0_r <= `PAC_RST_CTL0;
         plen_r <= `PAC_RST_PLEN;
         addr_r <= `PAC_RST_ADDR;
      end
      else
      begin
         ctl1_r <= ctl1_nxt;
         ctl0_r <= ctl0_nxt;
         plen_r <= plen_nxt;
         addr_r <= addr_nxt;
      end
   end
   // read mux; unmapped offsets read zero
   always_comb
   begin
      unique case (reg_addr)
         `PAC_OFS_CTL1: reg_rdata = ctl1_r;
         `PAC_OFS_CTL0: reg_rdata = ctl0_r;
         `PAC_OFS_PLEN: reg_rdata = plen_r;
         `PAC_OFS_ADDR: reg_rdata = addr_r;
         `PAC_OFS_STAT: reg_rdata = {5'h00, rx_crc_ok, tx_busy, rx_busy};
         default: reg_rdata = 8'h00;
      endcase
   end

   // ***************************************
   // receive path
   // ***************************************
   pac_pkg::pac_rx_st_t rst_r, rst_nxt;
   logic [4:0] pq_r, pq_nxt;
   logic prev_r, prev_nxt, first_r, first_nxt, ok_r, ok_nxt, ser_r, ser_nxt;
   logic [7:0] rsh_r, rsh_nxt, rrem_r, rrem_nxt, rbyte_r, rbyte_nxt;
   logic [2:0] rbc_r, rbc_nxt;
   logic [15:0] rcrc_r, rcrc_nxt, rcrc_upd;
   logic [8:0] rpn_r, rpn_nxt;
   logic rvld_r, rvld_nxt, flush_r, flush_nxt, rok_r, rok_nxt;
   logic [7:0] rin, dbyte;
   logic done_byte, addr_ok, sync_ok;
   assign rin = {rsh_r[6:0], rx_bit};
   assign dbyte = c0.white ? (rin ^ rpn_r[7:0]) : rin;
   assign rcrc_upd = crc_byte(rcrc_r, dbyte, c0.compat);
   assign done_byte = rx_bit_valid && (rbc_r == 3'h7);
   assign sync_ok = (pq_r >= {c1.pq_thr, 2'b00});
   assign rx_busy = (rst_r != pac_pkg::RX_HUNT);
   // address filter against own address and broadcasts
   always_comb
   begin
      unique case (c1.afilt)
         pac_pkg::AF_NONE: addr_ok = 1'b1;
         pac_pkg::AF_OWN: addr_ok = (dbyte == addr_r);
         pac_pkg::AF_B00: addr_ok = (dbyte == addr_r) || (dbyte == `PAC_BCAST_LO);
         pac_pkg::AF_B00FF: addr_ok = (dbyte == addr_r) || (dbyte == `PAC_BCAST_LO) || (dbyte == `PAC_BCAST_HI);
      endcase
   end
   // receive next state
   always_comb
   begin
      {rst_nxt, pq_nxt, prev_nxt, first_nxt, ok_nxt, ser_nxt} = {rst_r, pq_r, prev_r, first_r, ok_r, ser_r};
      {rsh_nxt, rrem_nxt, rbc_nxt, rcrc_nxt, rpn_nxt, rok_nxt} = {rsh_r, rrem_r, rbc_r, rcrc_r, rpn_r, rok_r};
      rbyte_nxt = rbyte_r;
      rvld_nxt = 1'b0;
      flush_nxt = 1'b0;
      if (rx_bit_valid)
      begin
         prev_nxt = rx_bit;
         if (rx_bit != prev_r)
            pq_nxt = (pq_r == `PAC_PQ_MAX) ? pq_r : pq_r + 5'h01;
         else
            pq_nxt = (pq_r == 5'h00) ? pq_r : pq_r - 5'h01;
         if (c0.fmt == pac_pkg::FMT_SYNC || c0.fmt == pac_pkg::FMT_ASYNC)
            ser_nxt = rx_bit;
      end
      if (rst_r != pac_pkg::RX_HUNT && !rx_enable)
         rst_nxt = pac_pkg::RX_HUNT;
      else
      begin
         if (rx_bit_valid && (rst_r == pac_pkg::RX_LEN || rst_r == pac_pkg::RX_DATA || rst_r == pac_pkg::RX_CRC))
         begin
            rsh_nxt = rin;
            rbc_nxt = rbc_r + 3'h1;
         end
         if (done_byte)
         begin
            rpn_nxt = pn9_adv8(rpn_r);
            rcrc_nxt = rcrc_upd;
         end
         unique case (rst_r)
            pac_pkg::RX_HUNT:
            begin
               // serial formats bypass the packet engine; pn9 format receives normally
               if (rx_enable && rx_sync_found && sync_ok && !c0.fmt[0])
               begin
                  rbc_nxt = 3'h0;
                  rcrc_nxt = `PAC_CRC_SEED;
                  rpn_nxt = `PAC_PN9_SEED;
                  first_nxt = (c1.afilt != pac_pkg::AF_NONE);
                  rrem_nxt = plen_r;
                  rst_nxt = (c0.len == pac_pkg::LEN_VAR) ? pac_pkg::RX_LEN : pac_pkg::RX_DATA;
               end
            end
            pac_pkg::RX_LEN:
               if (done_byte)
               begin
                  // oversize or empty length aborts the packet
                  if (dbyte == 8'h00 || dbyte > plen_r)
                  begin
                     flush_nxt = 1'b1;
                     rst_nxt = pac_pkg::RX_HUNT;
                  end
                  else
                  begin
                     rvld_nxt = 1'b1;
                     rbyte_nxt = dbyte;
                     rrem_nxt = dbyte;
                     rst_nxt = pac_pkg::RX_DATA;
                  end
               end
            pac_pkg::RX_DATA:
               if (done_byte)
               begin
                  first_nxt = 1'b0;
                  rvld_nxt = 1'b1;
                  rbyte_nxt = dbyte;
                  if (first_r && !addr_ok)
                  begin
                     flush_nxt = 1'b1;
                     rst_nxt = pac_pkg::RX_HUNT;
                  end
                  else if (c0.len != pac_pkg::LEN_INF)
                  begin
                     rrem_nxt = rrem_r - 8'h01;
                     if (rrem_r == 8'h01)
                     begin
                        ok_nxt = 1'b1;
                        rrem_nxt = 8'h02;
                        rst_nxt = c0.crc_en ? pac_pkg::RX_CRC : pac_pkg::RX_ST1;
                     end
                  end
               end
            pac_pkg::RX_CRC:
               if (done_byte)
               begin
                  rrem_nxt = rrem_r - 8'h01;
                  if (rrem_r == 8'h01)
                  begin
                     ok_nxt = (rcrc_upd == 16'h0000);
                     rst_nxt = pac_pkg::RX_ST1;
                  end
               end
            pac_pkg::RX_ST1:
            begin
               rvld_nxt = c1.append;
               rbyte_nxt = rx_rssi;
               rst_nxt = pac_pkg::RX_ST2;
            end
            pac_pkg::RX_ST2:
            begin
               rvld_nxt = c1.append;
               rbyte_nxt = {ok_r, rx_lqi};
               rok_nxt = ok_r;
               flush_nxt = c0.crc_en && !ok_r && c1.flush;
               rst_nxt = pac_pkg::RX_HUNT;
            end
            default: rst_nxt = pac_pkg::RX_HUNT;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {rst_r, pq_r, prev_r, first_r, ok_r, ser_r} <= {pac_pkg::RX_HUNT, 5'h00, 4'h0};
         {rsh_r, rrem_r, rbc_r, rcrc_r, rpn_r, rok_r} <= {8'h00, 8'h00, 3'h0, `PAC_CRC_SEED, `PAC_PN9_SEED, 1'b0};
         {rbyte_r, rvld_r, flush_r} <= {8'h00, 2'b00};
      end
      else
      begin
         {rst_r, pq_r, prev_r, first_r, ok_r, ser_r} <= {rst_nxt, pq_nxt, prev_nxt, first_nxt, ok_nxt, ser_nxt};
         {rsh_r, rrem_r, rbc_r, rcrc_r, rpn_r, rok_r} <= {rsh_nxt, rrem_nxt, rbc_nxt, rcrc_nxt, rpn_nxt, rok_nxt};
         {rbyte_r, rvld_r, flush_r} <= {rbyte_nxt, rvld_nxt, flush_nxt};
      end
   end
   assign {rx_byte_valid, rx_byte, rx_flush, rx_crc_ok, rx_serial_data} = {rvld_r, rbyte_r, flush_r, rok_r, ser_r};

   // ***************************************
   // transmit path
   // ***************************************
   pac_pkg::pac_tx_st_t tst_r, tst_nxt;
   logic [7:0] tsh_r, tsh_nxt, trem_r, trem_nxt, q_data, tld;
   logic [2:0] tbc_r, tbc_nxt;
   logic [15:0] tcrc_r, tcrc_nxt;
   logic [8:0] tpn_r, tpn_nxt;
   logic have_r, have_nxt, tfirst_r, tfirst_nxt, uf_r, uf_nxt, q_valid, q_ready;
   pac_fifo #(.W(8), .D(TXQ_DEPTH)) u_txq (.clk(sys_clk), .rst_n(rst_n), .in_valid(tx_byte_valid),
      .in_ready(tx_byte_ready), .in_data(tx_byte), .out_valid(q_valid), .out_ready(q_ready), .out_data(q_data));
   // the queue drains only when the shifter is empty, so a slow modulator backs up to the host
   assign q_ready = (tst_r == pac_pkg::TX_DATA) && !have_r;
   assign tld = (tst_r == pac_pkg::TX_CRC) ? tcrc_r[15:8] : q_data;
   always_comb
   begin
      {tst_nxt, tsh_nxt, trem_nxt, tbc_nxt, tcrc_nxt, tpn_nxt} = {tst_r, tsh_r, trem_r, tbc_r, tcrc_r, tpn_r};
      {have_nxt, tfirst_nxt} = {have_r, tfirst_r};
      uf_nxt = 1'b0;
      if (have_r && tx_bit_req)
      begin
         tsh_nxt = {tsh_r[6:0], 1'b0};
         tbc_nxt = tbc_r + 3'h1;
         have_nxt = (tbc_r != 3'h7);
      end
      if (tst_r == pac_pkg::TX_PN && tx_bit_req)
         tpn_nxt = pn9_step(tpn_r);
      // byte load: whitened copy goes out, crc runs on the plain byte
      if (!have_r && ((q_valid && q_ready) || tst_r == pac_pkg::TX_CRC))
      begin
         tsh_nxt = c0.white ? (tld ^ tpn_r[7:0]) : tld;
         tpn_nxt = pn9_adv8(tpn_r);
         have_nxt = 1'b1;
         tbc_nxt = 3'h0;
      end
      unique case (tst_r)
         pac_pkg::TX_IDLE:
            if (tx_start)
            begin
               tcrc_nxt = `PAC_CRC_SEED;
               tpn_nxt = `PAC_PN9_SEED;
               trem_nxt = plen_r;
               tfirst_nxt = (c0.len == pac_pkg::LEN_VAR);
               if (c0.fmt == pac_pkg::FMT_FIFO)
                  tst_nxt = pac_pkg::TX_DATA;
               else if (c0.fmt == pac_pkg::FMT_PN9)
                  tst_nxt = pac_pkg::TX_PN;
            end
         pac_pkg::TX_DATA:
            if (!have_r && q_valid)
            begin
               tcrc_nxt = crc_byte(tcrc_r, q_data, c0.compat);
               tfirst_nxt = 1'b0;
               trem_nxt = tfirst_r ? q_data : trem_r - 8'h01;
               if (c0.len != pac_pkg::LEN_INF && (tfirst_r ? (q_data == 8'h00) : (trem_r == 8'h01)))
               begin
                  trem_nxt = 8'h02;
                  tst_nxt = c0.crc_en ? pac_pkg::TX_CRC : pac_pkg::TX_END;
               end
            end
            else if (!have_r && (c0.len == pac_pkg::LEN_INF ? !tx_start : tx_bit_req))
            begin
               uf_nxt = (c0.len != pac_pkg::LEN_INF);
               tst_nxt = pac_pkg::TX_IDLE;
            end
         pac_pkg::TX_CRC:
            if (!have_r)
            begin
               tcrc_nxt = {tcrc_r[7:0], 8'h00};
               trem_nxt = trem_r - 8'h01;
               if (trem_r == 8'h01)
                  tst_nxt = pac_pkg::TX_END;
            end
         pac_pkg::TX_END:
            if (!have_r)
               tst_nxt = pac_pkg::TX_IDLE;
         pac_pkg::TX_PN:
            if (!tx_start)
               tst_nxt = pac_pkg::TX_IDLE;
         default: tst_nxt = pac_pkg::TX_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {tst_r, tsh_r, trem_r, tbc_r, tcrc_r, tpn_r} <= {pac_pkg::TX_IDLE, 19'h00000, `PAC_CRC_SEED, `PAC_PN9_SEED};
         {have_r, tfirst_r, uf_r} <= 3'h0;
      end
      else
      begin
         {tst_r, tsh_r, trem_r, tbc_r, tcrc_r, tpn_r} <= {tst_nxt, tsh_nxt, trem_nxt, tbc_nxt, tcrc_nxt, tpn_nxt};
         {have_r, tfirst_r, uf_r} <= {have_nxt, tfirst_nxt, uf_nxt};
      end
   end
   // serial formats pass the pin straight to the modulator
   always_comb
   begin
      unique case (c0.fmt)
         pac_pkg::FMT_FIFO: {tx_bit, tx_bit_avail} = {tsh_r[7], have_r};
         pac_pkg::FMT_PN9: {tx_bit, tx_bit_avail} = {tpn_r[0], tst_r == pac_pkg::TX_PN};
         default: {tx_bit, tx_bit_avail} = {gp_output_0_in, 1'b1};
      endcase
   end
   assign tx_busy = (tst_r != pac_pkg::TX_IDLE);
   assign tx_underflow = uf_r;

   // ***************************************
   // checks
   // ***************************************
   pq_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rx_bit_valid && rx_bit != prev_r && pq_r != 5'h1F |=> pq_r == $past(pq_r) + 5'h01)
      else $error("preamble counter did not rise");
   sync_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rst_r == pac_pkg::RX_HUNT ##1 rst_r != pac_pkg::RX_HUNT |-> $past(pq_r) >= {$past(c1.pq_thr), 2'b00})
      else $error("sync accepted below threshold");
   bad_flush_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rst_r == pac_pkg::RX_ST2 && c0.crc_en && !ok_r && c1.flush && rx_enable |=> rx_flush)
      else $error("bad crc packet not flushed");
   status_bytes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rst_r == pac_pkg::RX_ST1 && c1.append && rx_enable |=> rx_byte_valid && rx_byte == $past(rx_rssi)
      ##1 rx_byte_valid && rx_byte[7] == rx_crc_ok)
      else $error("status bytes missing");
   addr_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rst_r == pac_pkg::RX_DATA && rx_enable && first_r && done_byte && !addr_ok |=> rx_flush && !rx_busy)
      else $error("foreign address not dropped");
   rsv_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !ctl1_r[`PAC_CTL1_RSV_BIT] && !ctl0_r[`PAC_CTL0_RSV_BIT])
      else $error("reserved bit set");
   serial_tx_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      c0.fmt[0] |-> tx_bit == gp_output_0_in && tx_bit_avail)
      else $error("serial tx not from pin");
   len_max_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rst_r == pac_pkg::RX_LEN && rx_enable && done_byte && dbyte > plen_r |=> !rx_busy && rx_flush)
      else $error("oversize length accepted");
endmodule

// ---- pac_modem.sv ----
// modem side model: receive bit source and transmit bit taker
`timescale 1ns/1ps
module pac_modem (
   // clock
   input wire logic clk,
   // bitstreams
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_sync_found,
   output logic tx_bit_req,
   input wire logic tx_bit_avail,
   input wire logic tx_bit
);
   initial {rx_bit_valid, rx_bit, rx_sync_found, tx_bit_req} = 4'h0;
   // one bit every two cycles, msb first; between bits the line shows the inverse
   task send(input logic [7:0] b, input int n, input logic s);
      for (int i = 7; i > 7 - n; i--)
      begin
         @(negedge clk);
         {rx_bit_valid, rx_bit, rx_sync_found} = {1'b1, b[i], s};
         @(negedge clk);
         {rx_bit_valid, rx_bit, rx_sync_found} = {1'b0, ~b[i], 1'b0};
      end
   endtask
   // takes eight bits with uneven stalls; ok drops if a bit never shows
   task take(output logic [7:0] b, output logic ok);
      ok = 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         for (int w = 0; w < 40 && tx_bit_avail !== 1'b1; w++)
            @(negedge clk);
         ok &= tx_bit_avail;
         b[i] = tx_bit;
         tx_bit_req = 1'b1;
         @(negedge clk);
         tx_bit_req = 1'b0;
         repeat (1 + i % 3) @(negedge clk);
      end
   endtask
   // one bare request, as a modulator that runs on whether a bit is ready or not
   task kick;
      @(negedge clk);
      tx_bit_req = 1'b1;
      @(negedge clk);
      tx_bit_req = 1'b0;
   endtask
endmodule

// ---- pac_pkg.sv ----
// types shared by the packet engine
package pac_pkg;
   typedef enum logic [1:0] {FMT_FIFO = 2'b00, FMT_SYNC = 2'b01, FMT_PN9 = 2'b10, FMT_ASYNC = 2'b11} pac_fmt_t;
   typedef enum logic [1:0] {LEN_FIXED = 2'b00, LEN_VAR = 2'b01, LEN_INF = 2'b10, LEN_RSV = 2'b11} pac_len_t;
   typedef enum logic [1:0] {AF_NONE = 2'b00, AF_OWN = 2'b01, AF_B00 = 2'b10, AF_B00FF = 2'b11} pac_afilt_t;
   typedef enum logic [2:0] {RX_HUNT = 3'b000, RX_LEN = 3'b001, RX_DATA = 3'b010, RX_CRC = 3'b011,
      RX_ST1 = 3'b100, RX_ST2 = 3'b101} pac_rx_st_t;
   typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_DATA = 3'b001, TX_CRC = 3'b010, TX_END = 3'b011,
      TX_PN = 3'b100} pac_tx_st_t;
   typedef struct packed {
      logic [2:0] pq_thr;
      logic rsv;
      logic flush;
      logic append;
      pac_afilt_t afilt;
   } pac_ctl1_t;
   typedef struct packed {
      logic rsv;
      logic white;
      pac_fmt_t fmt;
      logic compat;
      logic crc_en;
      pac_len_t len;
   } pac_ctl0_t;
endpackage

// ---- packet_automation_control_test.sv ----
// self-checking bench of the packet engine
`timescale 1ns/1ps
`include "pac_consts.svh"
module packet_automation_control_test;
   logic sys_clk = 0, rst_n = 0, we = 0, rxen = 0, txv = 0, txs = 0, gp = 0;
   logic [5:0] ad = 0;
   logic [7:0] wd = 0, rd, rb, txd = 0, rssi = 0;
   logic [6:0] lqi = 0;
   logic rbv, fl, cok, rsd, txr, tba, tbit, busy, und, bv, rbit, sf, req;
   logic [31:0] lf = 32'h1b84;
   logic [7:0] got[$];
   int miscompares = 0, tests_run = 0, nfl = 0, nuf = 0;
   always #5 sys_clk = ~sys_clk;
   pac_engine #(.TXQ_DEPTH(8)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_we(we), .reg_addr(ad),
      .reg_wdata(wd), .reg_rdata(rd), .rx_enable(rxen), .rx_bit_valid(bv), .rx_bit(rbit),
      .rx_sync_found(sf), .rx_rssi(rssi), .rx_lqi(lqi), .rx_byte_valid(rbv), .rx_byte(rb),
      .rx_flush(fl), .rx_crc_ok(cok), .rx_serial_data(rsd), .tx_byte_valid(txv),
      .tx_byte_ready(txr), .tx_byte(txd), .tx_start(txs), .tx_bit_req(req), .tx_bit_avail(tba),
      .tx_bit(tbit), .tx_busy(busy), .tx_underflow(und), .gp_output_0_in(gp));
   pac_modem m (.clk(sys_clk), .rx_bit_valid(bv), .rx_bit(rbit), .rx_sync_found(sf),
      .tx_bit_req(req), .tx_bit_avail(tba), .tx_bit(tbit));
   // ****
   // fifo side watcher
   // ****
   always @(posedge sys_clk)
   begin
      if (rbv === 1'b1) got.push_back(rb);
      if (fl === 1'b1) nfl++;
      if (und === 1'b1) nuf++;
   end
   task results;
      $display("tests %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task cmp(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {we, ad, wd} = {1'b1, a, d};
      @(negedge sys_clk);
      we = 0;
   endtask
   // read is combinational, so sample once the address has settled
   task chk(input logic [5:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      ad = a;
      #1 cmp(rd, e);
   endtask
   function logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ `PAC_CRC_POLY : {c[14:0], 1'b0};
      return c;
   endfunction
   // one packet per receive window: the rx fifo never holds two
   task rxp(input logic [7:0] q[$], input logic bad);
      logic [15:0] c;
      c = `PAC_CRC_SEED;
      @(negedge sys_clk);
      rxen = 1;
      got.delete();
      nfl = 0;
      m.send(8'hAA, 8, 1'b0);
      m.send(8'h80, 1, 1'b1);
      foreach (q[i])
      begin
         m.send(q[i], 8, 1'b0);
         c = crc(c, q[i]);
      end
      m.send(c[15:8] ^ {7'h0, bad}, 8, 1'b0);
      m.send(c[7:0], 8, 1'b0);
      repeat (6) @(negedge sys_clk);
      rxen = 0;
   endtask
   initial
   begin
      logic [7:0] q[$];
      logic [15:0] c;
      logic ok, acc;
      logic [7:0] a, b;
      repeat (12) @(negedge sys_clk);
      rst_n = 1;
      chk(6'h07, 8'h04);
      chk(6'h08, 8'h45);
      chk(6'h06, 8'hFF);
      chk(6'h09, 8'h00);
      chk(6'h3F, 8'h00);
      wr(6'h07, 8'hFF);
      chk(6'h07, 8'hEF);
      wr(6'h08, 8'hC5);
      chk(6'h08, 8'h45);
      $display("registers done");
      // whitening and legacy crc stay off together
      wr(6'h08, 8'h05);
      wr(6'h09, 8'h5A);
      for (int f = 0; f < 16; f++)
      begin
         a = f[1:0] == 0 ? 8'h5A : f[1:0] == 1 ? 8'h00 : f[1:0] == 2 ? 8'hFF : 8'h33;
         wr(6'h07, {6'h09, f[3:2]});
         lf = nx(lf);
         {rssi, lqi} = lf[14:0];
         acc = f[3:2] == 0 || a == 8'h5A || (f[3] && a == 8'h00) || (f[3:2] == 3 && a == 8'hFF);
         rxp('{8'h02, a, lf[23:16]}, 1'b0);
         cmp(8'(nfl), {7'h0, !acc});
         if (acc)
         begin
            cmp(8'(got.size()), 8'h05);
            cmp(got[3], rssi);
            cmp(got[4], {1'b1, lqi});
         end
      end
      for (int f = 0; f < 2; f++)
      begin
         wr(6'h07, {4'h0, f[0], 3'h4});
         rxp('{8'h01, 8'h11}, 1'b1);
         cmp(8'(nfl), 8'(f));
         cmp({7'h0, cok}, 8'h00);
      end
      wr(6'h06, 8'h03);
      wr(6'h08, 8'h04);
      rxp('{8'h07, 8'h08, 8'h09}, 1'b0);
      cmp(8'(got.size()), 8'h05);
      wr(6'h08, 8'h05);
      rxp('{8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b0);
      cmp(8'(nfl), 8'h01);
      // no status bytes and no crc check: a broken crc still reads as good
      wr(6'h07, 8'h00);
      wr(6'h08, 8'h01);
      rxp('{8'h01, 8'h11}, 1'b1);
      cmp(8'(got.size()), 8'h02);
      cmp({7'h0, cok}, 8'h01);
      wr(6'h08, 8'h05);
      wr(6'h07, 8'hE4);
      rxp('{8'h01, 8'h11}, 1'b0);
      cmp(8'(got.size()), 8'h00);
      wr(6'h07, 8'h04);
      wr(6'h08, 8'h0D);
      rxp('{8'h01, 8'h11}, 1'b0);
      cmp({7'h0, cok}, 8'h00);
      $display("receive done");
      // fill the queue to the brim, then drain it through a stalling modem
      wr(6'h08, 8'h05);
      c = `PAC_CRC_SEED;
      for (int n = 0; n < 8; n++)
      begin
         lf = nx(lf);
         b = n == 0 ? 8'h07 : lf[7:0];
         q.push_back(b);
         c = crc(c, b);
         @(negedge sys_clk);
         {txv, txd} = {1'b1, b};
      end
      @(negedge sys_clk);
      txv = 0;
      cmp({7'h0, txr}, 8'h00);
      q.push_back(c[15:8]);
      q.push_back(c[7:0]);
      txs = 1;
      @(negedge sys_clk);
      txs = 0;
      foreach (q[i])
      begin
         m.take(b, ok);
         cmp({7'h0, ok}, 8'h01);
         if (!ok)
            results();
         cmp(b, q[i]);
      end
      repeat (4) @(negedge sys_clk);
      cmp({7'h0, busy}, 8'h00);
      $display("transmit done");
      // an empty queue meets a bare request: the packet is cut short
      nuf = 0;
      txs = 1;
      @(negedge sys_clk);
      txs = 0;
      m.kick();
      repeat (2) @(negedge sys_clk);
      cmp(8'(nuf), 8'h01);
      cmp({7'h0, busy}, 8'h00);
      for (int f = 0; f < 2; f++)
      begin
         wr(6'h08, f ? 8'h31 : 8'h11);
         repeat (8)
         begin
            lf = nx(lf);
            @(negedge sys_clk);
            gp = lf[0];
            #1 cmp({7'h0, tbit}, {7'h0, gp});
            m.send({lf[1], 7'h0}, 1, 1'b0);
            cmp({7'h0, rsd}, {7'h0, lf[1]});
         end
      end
      // test format still receives like the normal one
      wr(6'h08, 8'h25);
      rxp('{8'h01, 8'h11}, 1'b0);
      cmp(8'(got.size()), 8'h04);
      wr(6'h08, 8'h22);
      txs = 1;
      m.take(b, ok);
      cmp({7'h0, ok}, 8'h01);
      cmp(b, 8'hFF);
      cmp({7'h0, busy}, 8'h01);
      txs = 0;
      $display("formats done");
      results();
   end
endmodule
